// [dv/bmws_host_model.sv]
// Host processor model: host I/O cycles and payload strobe.
// Assumes the bench calls its tasks at a falling clock edge.
`timescale 1ns/1ps
module bmws_host_model
  import bmws_pkg::*;
(
  // Clock
  input  wire logic clk,
  // Host side
  output bmws_io_t  host_io,
  output logic      pay_wd_strobe
);
  initial begin
    host_io = '0;
    pay_wd_strobe = 1'b0;
  end

  // ==========================================================
  // Cycles
  // Released lines invert so stale values never match by luck
  task automatic io_cycle(input logic w, input logic [15:0] a,
                          input logic [7:0] d);
    @(negedge clk);
    host_io = '{valid: 1'b1, write: w, addr: a, data: d};
    @(negedge clk);
    host_io = '{valid: 1'b0, write: ~w, addr: ~a, data: ~d};
  endtask : io_cycle

  task automatic strobe_pay();
    @(negedge clk);
    pay_wd_strobe = 1'b1;
    @(negedge clk);
    pay_wd_strobe = 1'b0;
  endtask : strobe_pay
endmodule : bmws_host_model

// [dv/bmws_props.sv]
// Checker for the board supervision block.
// Bound to bmws_top; sees its ports only.
`timescale 1ns/1ps
module bmws_props
  import bmws_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rstn,
  // Inputs
  input  bmws_io_t        host_io,
  input  bmws_event_t     sensor_event,
  input  wire logic [2:0] post_rd_idx,
  // Outputs
  input  wire logic [7:0] post_rd_code,
  input  wire logic       norm_chan_hit,
  input  wire logic       mgmt_chan_hit,
  input  wire logic       payload_hard_reset,
  input  wire logic       bus_isolate,
  input  wire logic       mc_reset_n,
  input  wire logic       health_led,
  input  bmws_log_t       log_entry
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  // ==========================================================
  // Properties
  a_norm_hit: assert property (host_io.valid && (host_io.addr ==
    NORM_DATA_ADDR || host_io.addr == NORM_CMD_ADDR) |=> norm_chan_hit)
    else $error("normal channel hit missing");
  a_mgmt_hit: assert property (host_io.valid && (host_io.addr ==
    MGMT_DATA_ADDR || host_io.addr == MGMT_CMD_ADDR) |=> mgmt_chan_hit)
    else $error("management channel hit missing");
  a_no_hit: assert property (!host_io.valid |=>
    !norm_chan_hit && !mgmt_chan_hit) else $error("stray channel hit");
  a_post_range: assert property (post_rd_idx > 3'h4 |=>
    post_rd_code == 8'h00) else $error("code beyond depth not zero");
  a_led_latch: assert property (sensor_event.valid &&
    sensor_event.assert_ev && sensor_event.led_class == 2'h0 |=> health_led)
    else $error("latched event left led dark");
  a_iso_lead: assert property ($fell(mc_reset_n) |->
    $past(bus_isolate, 8) && bus_isolate) else $error("reset before isolate");
  a_rst_hold: assert property ($fell(mc_reset_n) |=>
    !mc_reset_n [*8]) else $error("controller reset too short");
  a_pay_log: assert property ($rose(payload_hard_reset) |->
    log_entry.valid && log_entry.code == 8'h01) else $error("no log entry");
  c_mc_reset: cover property ($fell(mc_reset_n));
  c_led_on: cover property ($rose(health_led));
  c_log: cover property (log_entry.valid);
endmodule : bmws_props

bind bmws_top bmws_props u_bmws_props (.clk(clk), .rstn(rstn),
  .host_io(host_io), .sensor_event(sensor_event), .post_rd_idx(post_rd_idx),
  .post_rd_code(post_rd_code), .norm_chan_hit(norm_chan_hit),
  .mgmt_chan_hit(mgmt_chan_hit), .payload_hard_reset(payload_hard_reset),
  .bus_isolate(bus_isolate), .mc_reset_n(mc_reset_n),
  .health_led(health_led), .log_entry(log_entry));

// [dv/bmws_top_tb.sv]
// Testbench for the board supervision block.
// Host model drives I/O and payload strobe; bench drives the rest on falling edges.
`timescale 1ns/1ps
module bmws_top_tb;
  import bmws_pkg::*;
  localparam int PW = 20;
  logic        clk = 0, rstn = 0, pay_en = 0, c_stb = 0, flt = 0, pcyc = 0;
  logic        fw_on = 1;
  logic [1:0]  act = 0;
  logic [2:0]  src = 0, idx = 0;
  bmws_event_t ev = '0;
  bmws_io_t    io;
  bmws_log_t   lg;
  logic        pstb, h_n, h_m, cmd, hrst, pdn, pcy, iso, bsel, mcr, led;
  logic [7:0]  code, cdat;
  logic [12:0] lcnt;
  int          failures = 0, checks_done = 0, cyc = 0, n;

  always #12.5 clk = ~clk;
  // Firmware strobe every 10 cycles, half the shortened timeout
  always @(negedge clk) begin
    cyc <= cyc + 1;
    c_stb <= fw_on && cyc % 10 == 0;
  end

  bmws_host_model u_bmws_host_model (.clk(clk), .host_io(io),
    .pay_wd_strobe(pstb));
  bmws_top #(.PAY_WD_CYC(PW), .CTRL_CYC(PW)) u_bmws_top (.clk(clk),
    .rstn(rstn), .host_io(io), .pay_wd_enable(pay_en), .pay_wd_action(act),
    .pay_wd_strobe(pstb), .ctrl_wd_strobe(c_stb), .bus_a_fault(flt),
    .sensor_event(ev), .sensor_src(src), .payload_power_cycled(pcyc),
    .post_rd_idx(idx), .post_rd_code(code), .norm_chan_hit(h_n),
    .mgmt_chan_hit(h_m), .chan_is_cmd(cmd), .chan_data(cdat),
    .payload_hard_reset(hrst), .payload_power_down(pdn),
    .payload_power_cycle(pcy), .bus_isolate(iso), .bus_b_select(bsel),
    .mc_reset_n(mcr), .health_led(led), .log_entry(lg), .log_count(lcnt));

  // ==========================================================
  // Helpers
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_of_test

  task automatic chk(input string s, input logic [15:0] e, g);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("Error %s expected %0h seen %0h", s, e, g);
    end
  endtask : chk

  // Bounded wait; n ends as falling edges seen plus one
  task automatic wt(input string s, input int w, input logic v);
    for (n = 1; n < 200 && (w == 0 ? iso : w == 1 ? mcr : lg.valid) !== v;
         n++) @(negedge clk);
    if (n == 200) begin
      failures++;
      $display("Error %s expected %0h seen timeout", s, v);
      end_of_test();
    end
  endtask : wt

  task automatic sev(input logic [1:0] c, input logic [2:0] t, s,
                     input logic a, e);
    ev = '{valid: 1'b1, assert_ev: a, led_class: c, thr: t, offset: 4'h0};
    src = s;
    @(negedge clk);
    ev.valid = 1'b0;
    chk("health_led", 16'(e), 16'(led));
    @(negedge clk);
  endtask : sev

  // ==========================================================
  // Scenarios
  task automatic t_chan();
    logic [15:0] a [5] = '{16'h0CA2, 16'h0CA3, 16'h0CA8, 16'h0CAC, 16'h0CA4};
    for (int i = 0; i < 5; i++) begin
      u_bmws_host_model.io_cycle(1'b1, a[i], 8'h10 + 8'(i));
      chk("norm_chan_hit", 16'(i < 2), 16'(h_n));
      chk("mgmt_chan_hit", 16'(i inside {2, 3}), 16'(h_m));
      if (i < 4) chk("chan_is_cmd", 16'(i % 2), 16'(cmd));
      if (i < 4) chk("chan_data", 16'h10 + 16'(i), 16'(cdat));
    end
    $display("t_chan end");
  endtask : t_chan

  task automatic t_post();
    for (int i = 0; i < 6; i++)
      u_bmws_host_model.io_cycle(1'b1, 16'h0080, 8'hA0 + 8'(i));
    u_bmws_host_model.io_cycle(1'b0, 16'h0080, 8'h55);
    for (int k = 0; k < 6; k++) begin
      idx = 3'(k);
      @(negedge clk);
      chk("post_rd_code", k < 5 ? 16'hA5 - 16'(k) : 16'h0, 16'(code));
    end
    $display("t_post end");
  endtask : t_post

  task automatic t_led();
    sev(2'h0, 3'h0, 3'h0, 1'b1, 1'b1);
    sev(2'h0, 3'h0, 3'h0, 1'b0, 1'b1);
    pcyc = 1'b1;
    @(negedge clk);
    pcyc = 1'b0;
    chk("health_led", 16'h0, 16'(led));
    sev(2'h1, 3'h1, 3'h1, 1'b1, 1'b1);
    sev(2'h1, 3'h1, 3'h1, 1'b0, 1'b0);
    sev(2'h1, 3'h4, 3'h1, 1'b1, 1'b1);
    sev(2'h1, 3'h4, 3'h1, 1'b0, 1'b0);
    sev(2'h1, 3'h0, 3'h3, 1'b1, 1'b0);
    sev(2'h2, 3'h0, 3'h2, 1'b1, 1'b1);
    sev(2'h2, 3'h0, 3'h2, 1'b0, 1'b0);
    $display("t_led end");
  endtask : t_led

  task automatic t_pay();
    for (int a = 0; a < 4; a++) begin
      act = 2'(a);
      pay_en = 1'b1;
      wt("log_entry.valid", 2, 1'b1);
      pay_en = 1'b0;
      chk("expiry time", 16'h1, 16'(n > PW && n < PW + 5));
      chk("hard_reset", 16'(a == 1), 16'(hrst));
      chk("power_down", 16'(a == 2), 16'(pdn));
      chk("power_cycle", 16'(a == 3), 16'(pcy));
      chk("log code", 16'(a), 16'(lg.code));
      @(negedge clk);
      chk("log_count", 16'(a + 1), 16'(lcnt));
      u_bmws_host_model.strobe_pay();
      chk("power_down", 16'h0, 16'(pdn));
    end
    pay_en = 1'b1;
    repeat (3) begin
      repeat (PW - 6) @(negedge clk);
      u_bmws_host_model.strobe_pay();
    end
    pay_en = 1'b0;
    chk("log_count", 16'h4, 16'(lcnt));
    $display("t_pay end");
  endtask : t_pay

  task automatic t_ctrl();
    chk("bus_isolate", 16'h0, 16'(iso));
    flt = 1'b1;
    fw_on = 1'b0;
    wt("bus_isolate", 0, 1'b1);
    chk("isolate time", 16'h1, 16'(n > PW - 10 && n < PW + 4));
    chk("mc_reset_n", 16'h1, 16'(mcr));
    wt("mc_reset_n", 1, 1'b0);
    chk("isolate hold", 16'(ISO_HOLD_CYC + 1), 16'(n));
    chk("bus_isolate", 16'h1, 16'(iso));
    wt("mc_reset_n", 1, 1'b1);
    chk("reset hold", 16'(MC_RST_CYC + 1), 16'(n));
    @(negedge clk);
    chk("bus_isolate", 16'h0, 16'(iso));
    chk("bus_b_select", 16'h1, 16'(bsel));
    fw_on = 1'b1;
    $display("t_ctrl end");
  endtask : t_ctrl

  initial begin
    repeat (4) @(negedge clk);
    rstn = 1'b1;
    chk("mc_reset_n", 16'h1, 16'(mcr));
    chk("health_led", 16'h0, 16'(led));
    chk("log_count", 16'h0, 16'(lcnt));
    t_chan();
    t_post();
    t_led();
    t_pay();
    t_ctrl();
    end_of_test();
  end
endmodule : bmws_top_tb

// [hdl/bmws_pkg.sv]
// Shared types and constants for the board supervision block.
// Assumes one 40 MHz clock and an active-low asynchronous reset.
package bmws_pkg;

  // ==========================================================
  // Timing
  localparam int unsigned CLK_HZ          = 40_000_000;
  localparam int unsigned CTRL_WD_MS      = 1000;
  localparam int unsigned CTRL_WD_CYC     = CLK_HZ / 1000 * CTRL_WD_MS;
  localparam int unsigned PAY_WD_CYC_DEF  = CLK_HZ;
  localparam int unsigned ISO_HOLD_CYC    = 16;
  localparam int unsigned MC_RST_CYC      = 64;

  // ==========================================================
  // Host channel decode
  localparam logic [15:0] NORM_DATA_ADDR  = 16'h0CA2;
  localparam logic [15:0] NORM_CMD_ADDR   = 16'h0CA3;
  localparam logic [15:0] MGMT_DATA_ADDR  = 16'h0CA8;
  localparam logic [15:0] MGMT_CMD_ADDR   = 16'h0CAC;
  localparam logic [15:0] POST_PORT_ADDR  = 16'h0080;

  // ==========================================================
  // Sizes
  localparam int unsigned POST_DEPTH      = 5;
  localparam int unsigned LOG_DEPTH_MIN   = 5000;
  localparam int unsigned NUM_THR         = 6;

  // ==========================================================
  // Event log
  localparam logic [7:0]  LOG_SRC_PAY_WD  = 8'h03;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    BMWS_ACT_NONE,
    BMWS_ACT_HARD_RESET,
    BMWS_ACT_POWER_DOWN,
    BMWS_ACT_POWER_CYCLE
  } bmws_action_t;

  // Threshold order: unr, uc, unc, lnr, lc, lnc
  typedef enum logic [2:0] {
    BMWS_THR_UNR,
    BMWS_THR_UC,
    BMWS_THR_UNC,
    BMWS_THR_LNR,
    BMWS_THR_LC,
    BMWS_THR_LNC
  } bmws_thr_t;

  typedef enum logic [1:0] {
    BMWS_LED_LATCH,
    BMWS_LED_CRIT,
    BMWS_LED_OFFSET
  } bmws_led_class_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [15:0] addr;
    logic [7:0]  data;
  } bmws_io_t;

  typedef struct packed {
    logic        valid;
    logic        assert_ev;
    logic [1:0]  led_class;
    logic [2:0]  thr;
    logic [3:0]  offset;
  } bmws_event_t;

  typedef struct packed {
    logic         valid;
    logic [7:0]   source;
    logic [7:0]   code;
  } bmws_log_t;

endpackage : bmws_pkg

// [hdl/bmws_top.sv]
// Board management supervision: watchdogs, health LED, POST codes,
// host channel decode and event log sequencing.
// Assumes host I/O cycles arrive decoded as single-cycle requests.
//
// Operation
// - Controller watchdog expires after one second
// - On expiry isolate buses, then reset controller
// - Payload watchdog expiry runs the selected action
// - Every payload expiry writes an event log entry
// - Snoop port 80 writes, keep five codes
// - Latching events light LED until power cycle
// - Critical threshold assert lights, deassert clears
// - Offset assert lights LED, deassert clears it
// - Decode normal and management channel addresses
// - Six event thresholds per threshold sensor
// - Event log holds at least 5000 entries
// - After isolation switch to redundant bus if bus A faulted
`timescale 1ns/1ps
module bmws_top
  import bmws_pkg::*;
#(
  parameter int unsigned PAY_WD_CYC = PAY_WD_CYC_DEF,
  parameter int unsigned CTRL_CYC   = CTRL_WD_CYC,
  parameter int unsigned LOG_DEPTH  = LOG_DEPTH_MIN,
  parameter int unsigned NUM_SRC    = 8
) (
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          rstn,
  // Host I/O cycles
  input  bmws_io_t           host_io,
  // Payload watchdog
  input  wire logic          pay_wd_enable,
  input  wire logic [1:0]    pay_wd_action,
  input  wire logic          pay_wd_strobe,
  // Controller watchdog
  input  wire logic          ctrl_wd_strobe,
  input  wire logic          bus_a_fault,
  // Sensor events
  input  bmws_event_t        sensor_event,
  input  wire logic [2:0]    sensor_src,
  input  wire logic          payload_power_cycled,
  // POST code readout
  input  wire logic [2:0]    post_rd_idx,
  output logic [7:0]         post_rd_code,
  // Host channel strobes
  output logic               norm_chan_hit,
  output logic               mgmt_chan_hit,
  output logic               chan_is_cmd,
  output logic [7:0]         chan_data,
  // Payload control
  output logic               payload_hard_reset,
  output logic               payload_power_down,
  output logic               payload_power_cycle,
  // Controller supervision
  output logic               bus_isolate,
  output logic               bus_b_select,
  output logic               mc_reset_n,
  // Health and log
  output logic               health_led,
  output bmws_log_t          log_entry,
  output logic [12:0]        log_count
);

  // ==========================================================
  // Parameter checks
  // Log count is a fixed-width port, so depth is capped by it
  if (LOG_DEPTH < LOG_DEPTH_MIN) begin : g_log_small
    $error("bmws_top: log too small");
  end
  if (LOG_DEPTH > 2 ** $bits(log_count) - 1) begin : g_log_large
    $error("bmws_top: log counter too narrow");
  end
  // Source flags are indexed straight by sensor_src
  if (NUM_SRC != 2 ** $bits(sensor_src)) begin : g_src_count
    $error("bmws_top: NUM_SRC must match sensor_src");
  end
  // Readout index is a fixed-width port
  if (POST_DEPTH > 2 ** $bits(post_rd_idx) - 1) begin : g_post_large
    $error("bmws_top: POST depth beyond readout index");
  end
  // Shift register keeps at least two codes
  if (POST_DEPTH < 2) begin : g_post_small
    $error("bmws_top: POST depth too small");
  end
  if (PAY_WD_CYC < 2 || CTRL_CYC < 2) begin : g_wd_short
    $error("bmws_top: watchdog timeout too short");
  end

  // ==========================================================
  // State
  localparam int unsigned RW = $clog2(MC_RST_CYC + ISO_HOLD_CYC + 1);

  typedef enum logic [1:0] {
    SUP_RUN,
    SUP_ISOLATE,
    SUP_RESET
  } bmws_sup_t;

  typedef struct packed {
    logic [POST_DEPTH-1:0][7:0] post;
    logic [7:0]                 post_rd;
    logic                       norm_hit;
    logic                       mgmt_hit;
    logic                       is_cmd;
    logic [7:0]                 cdata;
    logic                       hard_reset;
    logic                       power_down;
    logic                       power_cycle;
    bmws_sup_t                  sup;
    logic [RW-1:0]              sup_cnt;
    logic                       isolate;
    logic                       bus_b;
    logic                       mc_rst_n;
    logic [NUM_SRC-1:0]         latch_src;
    logic [NUM_SRC-1:0]         crit_src;
    logic [NUM_SRC-1:0]         ofs_src;
    logic                       led;
    bmws_log_t                  log;
    logic [12:0]                log_cnt;
  } bmws_st_t;

  bmws_st_t st_q;
  bmws_st_t st_d;

  logic pay_expire;
  logic ctrl_expire;

  // ==========================================================
  // Watchdogs
  bmws_wdog #(
    .TIMEOUT (PAY_WD_CYC)
  ) u_pay_wd (
    .clk    (clk),
    .rstn   (rstn),
    .enable (pay_wd_enable),
    .strobe (pay_wd_strobe),
    .expire (pay_expire)
  );

  // Firmware must keep strobe spacing well under CTRL_CYC
  bmws_wdog #(
    .TIMEOUT (CTRL_CYC)
  ) u_ctrl_wd (
    .clk    (clk),
    .rstn   (rstn),
    .enable (st_q.sup == SUP_RUN),
    .strobe (ctrl_wd_strobe),
    .expire (ctrl_expire)
  );

  // ==========================================================
  // Decode
  // Each channel owns a data and a command address
  function automatic logic addr_hit(input logic [15:0] a,
                                    input logic [15:0] b0,
                                    input logic [15:0] b1);
    addr_hit = (a == b0) || (a == b1);
  endfunction : addr_hit

  // ==========================================================
  // Next state
  always_comb begin
    st_d             = st_q;
    st_d.norm_hit    = 1'b0;
    st_d.mgmt_hit    = 1'b0;
    st_d.hard_reset  = 1'b0;
    st_d.power_cycle = 1'b0;
    st_d.log.valid   = 1'b0;

    // ==========================================================
    // Host decode and POST snoop
    if (host_io.valid) begin
      if (addr_hit(host_io.addr, NORM_DATA_ADDR, NORM_CMD_ADDR)) begin
        st_d.norm_hit = 1'b1;
        st_d.is_cmd   = (host_io.addr == NORM_CMD_ADDR);
        st_d.cdata    = host_io.data;
      end else if (addr_hit(host_io.addr, MGMT_DATA_ADDR,
                            MGMT_CMD_ADDR)) begin
        st_d.mgmt_hit = 1'b1;
        st_d.is_cmd   = (host_io.addr == MGMT_CMD_ADDR);
        st_d.cdata    = host_io.data;
      end else if (host_io.write && host_io.addr == POST_PORT_ADDR) begin
        // Newest at index 0; oldest drops off
        st_d.post = {st_q.post[POST_DEPTH-2:0], host_io.data};
      end
    end
    st_d.post_rd = (post_rd_idx < 3'(POST_DEPTH)) ?
                   st_q.post[post_rd_idx] : 8'h00;

    // ==========================================================
    // Payload watchdog action; expiry beats a strobe in one cycle
    if (pay_wd_strobe) begin
      st_d.power_down = 1'b0;
    end
    if (pay_expire) begin
      unique case (bmws_action_t'(pay_wd_action))
        BMWS_ACT_NONE:        ;
        BMWS_ACT_HARD_RESET:  st_d.hard_reset  = 1'b1;
        BMWS_ACT_POWER_DOWN:  st_d.power_down  = 1'b1;
        BMWS_ACT_POWER_CYCLE: st_d.power_cycle = 1'b1;
      endcase
      st_d.log.valid  = 1'b1;
      st_d.log.source = LOG_SRC_PAY_WD;
      st_d.log.code   = {6'h00, pay_wd_action};
      if (st_q.log_cnt != 13'(LOG_DEPTH)) begin
        st_d.log_cnt = st_q.log_cnt + 13'h0001;
      end
    end

    // ==========================================================
    // Controller supervision: isolate first, then reset
    unique case (st_q.sup)
      SUP_RUN: begin
        st_d.mc_rst_n = 1'b1;
        if (ctrl_expire) begin
          st_d.sup     = SUP_ISOLATE;
          st_d.isolate = 1'b1;
          st_d.sup_cnt = '0;
        end
      end
      SUP_ISOLATE: begin
        // Bus cut stays on through the reset that follows
        st_d.sup_cnt = st_q.sup_cnt + 1'b1;
        if (st_q.sup_cnt == RW'(ISO_HOLD_CYC - 1)) begin
          st_d.sup      = SUP_RESET;
          st_d.mc_rst_n = 1'b0;
          st_d.sup_cnt  = '0;
        end
      end
      SUP_RESET: begin
        st_d.sup_cnt = st_q.sup_cnt + 1'b1;
        if (st_q.sup_cnt == RW'(MC_RST_CYC - 1)) begin
          st_d.sup      = SUP_RUN;
          st_d.mc_rst_n = 1'b1;
          st_d.isolate  = 1'b0;
          st_d.bus_b    = bus_a_fault;
        end
      end
    endcase

    // ==========================================================
    // Health LED; set wins over clear
    // One flag per source, so one clear cannot hide another
    if (payload_power_cycled) begin
      st_d.latch_src = '0;
    end
    if (sensor_event.valid) begin
      unique case (bmws_led_class_t'(sensor_event.led_class))
        BMWS_LED_LATCH: begin
          if (sensor_event.assert_ev) begin
            st_d.latch_src[sensor_src] = 1'b1;
          end
        end
        BMWS_LED_CRIT: begin
          // Only critical thresholds of the six steer the LED
          if (bmws_thr_t'(sensor_event.thr) == BMWS_THR_UC ||
              bmws_thr_t'(sensor_event.thr) == BMWS_THR_LC) begin
            st_d.crit_src[sensor_src] = sensor_event.assert_ev;
          end
        end
        BMWS_LED_OFFSET: begin
          st_d.ofs_src[sensor_src] = sensor_event.assert_ev;
        end
        default: ;
      endcase
    end
    st_d.led = |{st_d.latch_src, st_d.crit_src, st_d.ofs_src};
  end

  // ==========================================================
  // State register; resets quiet, controller out of reset
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_q          <= '0;
      st_q.sup      <= SUP_RUN;
      st_q.mc_rst_n <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  // ==========================================================
  // Outputs
  assign post_rd_code        = st_q.post_rd;
  assign norm_chan_hit       = st_q.norm_hit;
  assign mgmt_chan_hit       = st_q.mgmt_hit;
  assign chan_is_cmd         = st_q.is_cmd;
  assign chan_data           = st_q.cdata;
  assign payload_hard_reset  = st_q.hard_reset;
  assign payload_power_down  = st_q.power_down;
  assign payload_power_cycle = st_q.power_cycle;
  assign bus_isolate         = st_q.isolate;
  assign bus_b_select        = st_q.bus_b;
  assign mc_reset_n          = st_q.mc_rst_n;
  assign health_led          = st_q.led;
  assign log_entry           = st_q.log;
  assign log_count           = st_q.log_cnt;

endmodule : bmws_top

// [hdl/bmws_wdog.sv]
// Generic restartable watchdog counter.
// Assumes strobe is a one-cycle pulse synchronous to clk.
`timescale 1ns/1ps
module bmws_wdog
  import bmws_pkg::*;
#(
  parameter int unsigned TIMEOUT = 1000
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rstn,
  // Control
  input  wire logic enable,
  input  wire logic strobe,
  // Status
  output logic      expire
);

  localparam int unsigned CW = $clog2(TIMEOUT + 1);

  if (TIMEOUT < 2) begin : g_timeout_small
    $error("bmws_wdog: TIMEOUT too small");
  end

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          expire;
  } bmws_wdog_st_t;

  bmws_wdog_st_t st_q;
  bmws_wdog_st_t st_d;

  // ==========================================================
  // Counter
  always_comb begin
    st_d        = st_q;
    st_d.expire = 1'b0;
    if (!enable || strobe) begin
      st_d.cnt = '0;
    end else if (st_q.cnt == CW'(TIMEOUT - 1)) begin
      st_d.cnt    = '0;
      st_d.expire = 1'b1;
    end else begin
      st_d.cnt = st_q.cnt + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign expire = st_q.expire;

endmodule : bmws_wdog
